//--- lmx_exec.sv
// load, modulus and restartable string execution unit
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
//==========================================
module lmx_exec (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// floating trap status
	input wire logic [31:0] i_fp_pc,
	input wire logic [63:0] i_fp_dest,
	// memory
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [1:0] o_mem_size,
	output logic [31:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	input wire logic i_mem_ack,
	input wire logic [1:0] i_mem_fault,
	input wire logic [31:0] i_mem_rdata
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RD = 5'b00010,
		ST_RD2 = 5'b00100,
		ST_WR = 5'b01000,
		ST_DIV = 5'b10000
	} lmx_st_t;

	lmx_st_t st_ff, nxt_st;
	lmx_pkg::lmx_op_t op_ff, nxt_op, op_in;
	lmx_pkg::lmx_cause_t cause_ff, nxt_cause;
	logic [31:0] opa_ff, nxt_opa, opb_ff, nxt_opb, res_ff, nxt_res;
	logic [31:0] flo_ff, nxt_flo, fhi_ff, nxt_fhi;
	logic [31:0] cnt_ff, nxt_cnt, src_ff, nxt_src, pat_ff, nxt_pat;
	logic [3:0] flg_ff, nxt_flg;
	logic req_ff, nxt_req, we_ff, nxt_we, mgo_ff, nxt_mgo;
	logic [1:0] size_ff, nxt_size;
	logic [31:0] maddr_ff, nxt_maddr, mwdata_ff, nxt_mwdata, rdata_ff, nxt_rdata;
	logic [31:0] ea, imm, pat_rot;
	logic start, mod_done, mod_ovf;
	logic [31:0] mod_rem;

	assign start = i_wr && (i_addr == lmx_pkg::OFS_CTRL) && (st_ff == ST_IDLE);
	assign op_in = lmx_pkg::lmx_op_t'(i_wdata[3:0]);
	// effective address: base plus displacement
	assign ea = opa_ff + opb_ff;
	assign pat_rot = {pat_ff[7:0], pat_ff[31:8]};
	// short form carries a signed halfword, long form a full word
	assign imm = (op_in == lmx_pkg::OP_LDI16) ? {{16{opa_ff[15]}}, opa_ff[15:0]} : opa_ff;

	//==========================================
	// modulus unit
	lmx_mod #(.W(32)) u_mod (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_start(mgo_ff),
		.i_signed(op_ff == lmx_pkg::OP_MODS),
		.i_dividend(opb_ff),
		.i_divisor(opa_ff),
		.o_done(mod_done),
		.o_rem(mod_rem),
		.o_ovf(mod_ovf)
	);

	function automatic lmx_pkg::lmx_cause_t f_cause(input logic [1:0] flt, input logic wr);
		lmx_pkg::lmx_cause_t c;
		c = lmx_pkg::C_MEM;
		if (flt == lmx_pkg::FLT_PAGE)
			c = lmx_pkg::C_PAGE;
		else if (flt == lmx_pkg::FLT_PROT)
			c = wr ? lmx_pkg::C_WPROT : lmx_pkg::C_RPROT;
		return c;
	endfunction

	//==========================================
	// execution
	always_comb
	begin
		nxt_st = st_ff;
		nxt_op = op_ff;
		nxt_cause = cause_ff;
		nxt_opa = opa_ff;
		nxt_opb = opb_ff;
		nxt_res = res_ff;
		nxt_flo = flo_ff;
		nxt_fhi = fhi_ff;
		nxt_cnt = cnt_ff;
		nxt_src = src_ff;
		nxt_pat = pat_ff;
		nxt_flg = flg_ff;
		nxt_req = req_ff;
		nxt_we = we_ff;
		nxt_size = size_ff;
		nxt_maddr = maddr_ff;
		nxt_mwdata = mwdata_ff;
		nxt_mgo = 1'b0;
		unique case (st_ff)
			ST_IDLE:
			begin
				// port writes to the operand and string registers land only while idle
				if (i_wr && i_addr == lmx_pkg::OFS_OPA)
					nxt_opa = i_wdata;
				if (i_wr && i_addr == lmx_pkg::OFS_OPB)
					nxt_opb = i_wdata;
				if (i_wr && i_addr == lmx_pkg::OFS_CNT)
					nxt_cnt = i_wdata;
				if (i_wr && i_addr == lmx_pkg::OFS_SRC)
					nxt_src = i_wdata;
				if (i_wr && i_addr == lmx_pkg::OFS_PAT)
					nxt_pat = i_wdata;
				if (start)
				begin
					nxt_op = op_in;
					nxt_cause = lmx_pkg::C_NONE;
					nxt_maddr = ea;
					nxt_we = 1'b0;
					nxt_size = lmx_pkg::SZ_W;
					unique case (op_in)
						lmx_pkg::OP_LDA:
							nxt_res = ea;
						lmx_pkg::OP_LDFS:
						begin
							nxt_res = i_fp_pc;
							nxt_flo = i_fp_dest[31:0];
							nxt_fhi = i_fp_dest[63:32];
						end
						lmx_pkg::OP_LDI16, lmx_pkg::OP_LDI32:
						begin
							nxt_res = imm;
							nxt_flg = {imm[31], imm == lmx_pkg::RST_WORD, 2'b00};
						end
						lmx_pkg::OP_LDQ:
						begin
							nxt_res = {28'h000_0000, opa_ff[3:0]};
							nxt_flg = {1'b0, opa_ff[3:0] == 4'h0, 2'b00};
						end
						lmx_pkg::OP_MODS, lmx_pkg::OP_MODU:
						begin
							if (opa_ff == lmx_pkg::RST_WORD)
								nxt_cause = lmx_pkg::C_DIVZ;
							else
							begin
								nxt_mgo = 1'b1;
								nxt_st = ST_DIV;
							end
						end
						lmx_pkg::OP_LDB, lmx_pkg::OP_LDBU:
						begin
							nxt_size = lmx_pkg::SZ_B;
							nxt_req = 1'b1;
							nxt_st = ST_RD;
						end
						lmx_pkg::OP_LDH, lmx_pkg::OP_LDHU:
						begin
							nxt_size = lmx_pkg::SZ_H;
							nxt_req = 1'b1;
							nxt_st = ST_RD;
						end
						lmx_pkg::OP_LDW, lmx_pkg::OP_LDS, lmx_pkg::OP_LDD:
						begin
							nxt_req = 1'b1;
							nxt_st = ST_RD;
						end
						lmx_pkg::OP_FILL:
						begin
							nxt_size = lmx_pkg::SZ_B;
							nxt_maddr = src_ff;
							nxt_mwdata = {24'h00_0000, pat_ff[7:0]};
							nxt_we = 1'b1;
							nxt_req = (cnt_ff != lmx_pkg::RST_WORD);
							nxt_st = (cnt_ff != lmx_pkg::RST_WORD) ? ST_WR : ST_IDLE;
						end
						lmx_pkg::OP_COPY:
						begin
							nxt_size = lmx_pkg::SZ_B;
							nxt_maddr = src_ff;
							nxt_req = (cnt_ff != lmx_pkg::RST_WORD);
							nxt_st = (cnt_ff != lmx_pkg::RST_WORD) ? ST_RD : ST_IDLE;
						end
					endcase
				end
			end
			ST_RD:
			begin
				if (i_mem_ack)
				begin
					nxt_req = 1'b0;
					nxt_st = ST_IDLE;
					if (i_mem_fault != lmx_pkg::FLT_NONE)
						nxt_cause = f_cause(i_mem_fault, 1'b0);
					else
					begin
						unique case (op_ff)
							lmx_pkg::OP_LDB:
								nxt_res = {{24{i_mem_rdata[7]}}, i_mem_rdata[7:0]};
							lmx_pkg::OP_LDBU:
								nxt_res = {24'h00_0000, i_mem_rdata[7:0]};
							lmx_pkg::OP_LDH:
								nxt_res = {{16{i_mem_rdata[15]}}, i_mem_rdata[15:0]};
							lmx_pkg::OP_LDHU:
								nxt_res = {16'h0000, i_mem_rdata[15:0]};
							lmx_pkg::OP_LDS:
								nxt_flo = i_mem_rdata;
							lmx_pkg::OP_LDD:
							begin
								nxt_flo = i_mem_rdata;
								nxt_maddr = maddr_ff + lmx_pkg::WORD_STEP;
								nxt_req = 1'b1;
								nxt_st = ST_RD2;
							end
							lmx_pkg::OP_COPY:
							begin
								// byte held in the write data until stored
								nxt_mwdata = {24'h00_0000, i_mem_rdata[7:0]};
								nxt_maddr = pat_ff;
								nxt_we = 1'b1;
								nxt_req = 1'b1;
								nxt_st = ST_WR;
							end
							default:
								nxt_res = i_mem_rdata;
						endcase
					end
				end
			end
			ST_RD2:
			begin
				if (i_mem_ack)
				begin
					nxt_req = 1'b0;
					nxt_st = ST_IDLE;
					if (i_mem_fault != lmx_pkg::FLT_NONE)
						nxt_cause = f_cause(i_mem_fault, 1'b0);
					else
						nxt_fhi = i_mem_rdata;
				end
			end
			ST_WR:
			begin
				if (i_mem_ack)
				begin
					nxt_req = 1'b0;
					nxt_we = 1'b0;
					nxt_st = ST_IDLE;
					// a faulted byte leaves r0..r2 untouched so a rerun resumes here
					if (i_mem_fault != lmx_pkg::FLT_NONE)
						nxt_cause = f_cause(i_mem_fault, 1'b1);
					else
					begin
						nxt_cnt = cnt_ff - 32'h0000_0001;
						nxt_src = src_ff + 32'h0000_0001;
						nxt_pat = (op_ff == lmx_pkg::OP_FILL) ? pat_rot : pat_ff + 32'h0000_0001;
						if (cnt_ff != 32'h0000_0001)
						begin
							nxt_req = 1'b1;
							if (op_ff == lmx_pkg::OP_FILL)
							begin
								nxt_we = 1'b1;
								nxt_maddr = src_ff + 32'h0000_0001;
								nxt_mwdata = {24'h00_0000, pat_rot[7:0]};
								nxt_st = ST_WR;
							end
							else
							begin
								nxt_maddr = src_ff + 32'h0000_0001;
								nxt_st = ST_RD;
							end
						end
					end
				end
			end
			ST_DIV:
			begin
				if (mod_done)
				begin
					nxt_res = mod_rem;
					nxt_flg = {2'b00, mod_ovf, 1'b0};
					nxt_st = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st_ff <= ST_IDLE;
			op_ff <= lmx_pkg::OP_LDA;
			cause_ff <= lmx_pkg::C_NONE;
			opa_ff <= lmx_pkg::RST_WORD;
			opb_ff <= lmx_pkg::RST_WORD;
			res_ff <= lmx_pkg::RST_WORD;
			flo_ff <= lmx_pkg::RST_WORD;
			fhi_ff <= lmx_pkg::RST_WORD;
			cnt_ff <= lmx_pkg::RST_WORD;
			src_ff <= lmx_pkg::RST_WORD;
			pat_ff <= lmx_pkg::RST_WORD;
			flg_ff <= 4'h0;
			req_ff <= 1'b0;
			we_ff <= 1'b0;
			mgo_ff <= 1'b0;
			size_ff <= lmx_pkg::SZ_W;
			maddr_ff <= lmx_pkg::RST_WORD;
			mwdata_ff <= lmx_pkg::RST_WORD;
		end
		else
		begin
			st_ff <= nxt_st;
			op_ff <= nxt_op;
			cause_ff <= nxt_cause;
			opa_ff <= nxt_opa;
			opb_ff <= nxt_opb;
			res_ff <= nxt_res;
			flo_ff <= nxt_flo;
			fhi_ff <= nxt_fhi;
			cnt_ff <= nxt_cnt;
			src_ff <= nxt_src;
			pat_ff <= nxt_pat;
			flg_ff <= nxt_flg;
			req_ff <= nxt_req;
			we_ff <= nxt_we;
			mgo_ff <= nxt_mgo;
			size_ff <= nxt_size;
			maddr_ff <= nxt_maddr;
			mwdata_ff <= nxt_mwdata;
		end
	end

	//==========================================
	// register read port
	always_comb
	begin
		nxt_rdata = lmx_pkg::RST_WORD;
		if (i_rd)
		begin
			unique case (i_addr)
				lmx_pkg::OFS_CTRL:
				begin
					nxt_rdata[3:0] = op_ff;
					nxt_rdata[lmx_pkg::CTRL_BUSY_BIT] = (st_ff != ST_IDLE);
					nxt_rdata[lmx_pkg::CTRL_CAUSE_LSB +: 3] = cause_ff;
				end
				lmx_pkg::OFS_OPA: nxt_rdata = opa_ff;
				lmx_pkg::OFS_OPB: nxt_rdata = opb_ff;
				lmx_pkg::OFS_RES: nxt_rdata = res_ff;
				lmx_pkg::OFS_FLO: nxt_rdata = flo_ff;
				lmx_pkg::OFS_FHI: nxt_rdata = fhi_ff;
				lmx_pkg::OFS_FLAGS: nxt_rdata = {28'h000_0000, flg_ff};
				lmx_pkg::OFS_CNT: nxt_rdata = cnt_ff;
				lmx_pkg::OFS_SRC: nxt_rdata = src_ff;
				lmx_pkg::OFS_PAT: nxt_rdata = pat_ff;
				default: nxt_rdata = lmx_pkg::RST_WORD;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			rdata_ff <= lmx_pkg::RST_WORD;
		else
			rdata_ff <= nxt_rdata;
	end

	assign o_rdata = rdata_ff;
	assign o_mem_req = req_ff;
	assign o_mem_we = we_ff;
	assign o_mem_size = size_ff;
	assign o_mem_addr = maddr_ff;
	assign o_mem_wdata = mwdata_ff;

	//==========================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	logic fill_ok, ack_flt;
	assign fill_ok = st_ff == ST_WR && op_ff == lmx_pkg::OP_FILL && i_mem_ack
		&& i_mem_fault == lmx_pkg::FLT_NONE;
	assign ack_flt = i_mem_ack && i_mem_fault != lmx_pkg::FLT_NONE;

	property p_fill_step;
		fill_ok |=> cnt_ff == $past(cnt_ff) - 32'h0000_0001 && src_ff == $past(src_ff)
			+ 32'h0000_0001 && pat_ff == $past(pat_rot);
	endproperty
	a_fill_step: assert property (p_fill_step) else $error("fill step wrong");

	property p_fill_data;
		req_ff && we_ff && op_ff == lmx_pkg::OP_FILL |-> mwdata_ff[7:0] == pat_ff[7:0]
			&& maddr_ff == src_ff;
	endproperty
	a_fill_data: assert property (p_fill_data) else $error("fill byte wrong");

	property p_str_restart;
		(st_ff == ST_WR && ack_flt) |=> cnt_ff == $past(cnt_ff) && src_ff == $past(src_ff)
			&& st_ff == ST_IDLE;
	endproperty
	a_str_restart: assert property (p_str_restart) else $error("restart state lost");

	property p_copy_dest;
		req_ff && we_ff && op_ff == lmx_pkg::OP_COPY |-> maddr_ff == pat_ff;
	endproperty
	a_copy_dest: assert property (p_copy_dest) else $error("copy dest wrong");

	property p_lda;
		start && op_in == lmx_pkg::OP_LDA |=> res_ff == $past(ea)
			&& cause_ff == lmx_pkg::C_NONE && !req_ff;
	endproperty
	a_lda: assert property (p_lda) else $error("address load wrong");

	property p_ldb;
		st_ff == ST_RD && op_ff == lmx_pkg::OP_LDB && i_mem_ack && !ack_flt |=>
			res_ff[31:8] == {24{res_ff[7]}} && res_ff[7:0] == $past(i_mem_rdata[7:0]);
	endproperty
	a_ldb: assert property (p_ldb) else $error("byte sign extend wrong");

	property p_ldi;
		start && op_in == lmx_pkg::OP_LDI32 |=> flg_ff[lmx_pkg::FLG_N] == res_ff[31]
			&& flg_ff[lmx_pkg::FLG_Z] == (res_ff == 32'h0000_0000) && flg_ff[1:0] == 2'b00;
	endproperty
	a_ldi: assert property (p_ldi) else $error("immediate flags wrong");

	property p_ldq;
		start && op_in == lmx_pkg::OP_LDQ |=> res_ff[31:4] == 28'h000_0000
			&& flg_ff[lmx_pkg::FLG_N] == 1'b0 && flg_ff[1:0] == 2'b00;
	endproperty
	a_ldq: assert property (p_ldq) else $error("quick load wrong");

	property p_divz;
		start && (op_in == lmx_pkg::OP_MODS || op_in == lmx_pkg::OP_MODU)
			&& opa_ff == 32'h0000_0000 |=> cause_ff == lmx_pkg::C_DIVZ && st_ff == ST_IDLE;
	endproperty
	a_divz: assert property (p_divz) else $error("zero divisor not trapped");

	property p_rdflt;
		st_ff == ST_RD && i_mem_ack && i_mem_fault == lmx_pkg::FLT_PAGE |=>
			cause_ff == lmx_pkg::C_PAGE && !req_ff && st_ff == ST_IDLE;
	endproperty
	a_rdflt: assert property (p_rdflt) else $error("read fault not trapped");

	c_fill_done: cover property (fill_ok && cnt_ff == 32'h0000_0001);
	c_copy_done: cover property (st_ff == ST_WR && op_ff == lmx_pkg::OP_COPY && i_mem_ack);
	c_mod_done: cover property (st_ff == ST_DIV && mod_done);
	c_ldd_done: cover property (st_ff == ST_RD2 && i_mem_ack);
endmodule

//--- lmx_exec_tb.sv
// self-checking bench for the load, modulus and string unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module lmx_exec_tb;
	logic i_clk;
	logic i_resetn;
	logic [7:0] i_addr;
	logic [31:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic [31:0] i_fp_pc;
	logic [63:0] i_fp_dest;
	logic mreq;
	logic mwe;
	logic mack;
	logic [1:0] msize;
	logic [1:0] mflt;
	logic [1:0] flt_code;
	logic [31:0] maddr;
	logic [31:0] mwdata;
	logic [31:0] mrdata;
	logic [31:0] flt_addr;
	logic [3:0] delay;
	int error_cnt = 0;
	int compares = 0;
	lmx_exec lmx_exec_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_fp_pc(i_fp_pc), .i_fp_dest(i_fp_dest), .o_mem_req(mreq), .o_mem_we(mwe),
		.o_mem_size(msize), .o_mem_addr(maddr), .o_mem_wdata(mwdata),
		.i_mem_ack(mack), .i_mem_fault(mflt), .i_mem_rdata(mrdata));
	lmx_mem lmx_mem_i (.i_clk(i_clk), .i_req(mreq), .i_we(mwe), .i_size(msize),
		.i_addr(maddr), .i_wdata(mwdata), .o_ack(mack), .o_fault(mflt), .o_rdata(mrdata),
		.i_delay(delay), .i_flt_addr(flt_addr), .i_flt_code(flt_code));
	//==========================================
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask
	task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		`CHK(n, e, v)
	endtask
	task automatic ctl(input logic [3:0] d, input logic [31:0] a, input logic [1:0] c);
		@(posedge i_clk);
		delay <= d;
		flt_addr <= a;
		flt_code <= c;
	endtask
	// busy is polled with a bound, so a hung unit shows as a busy mismatch
	task automatic run(input logic [3:0] op, input logic [2:0] c);
		logic [31:0] v;
		wr(lmx_pkg::OFS_CTRL, {28'h0, op});
		for (int n = 0; n < 100; n++)
		begin
			rd(lmx_pkg::OFS_CTRL, v);
			if (!v[8])
				break;
		end
		`CHK("busy", 1'b0, v[8])
		`CHK("cause", c, v[14:12])
	endtask
	task automatic ld(input logic [3:0] op, input logic [31:0] e);
		run(op, lmx_pkg::C_NONE);
		chk("res", lmx_pkg::OFS_RES, e);
	endtask
	task automatic xo(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] r, input logic [31:0] f);
		wr(lmx_pkg::OFS_OPA, a);
		wr(lmx_pkg::OFS_OPB, b);
		ld(op, r);
		chk("flags", lmx_pkg::OFS_FLAGS, f);
	endtask
	//==========================================
	// scenarios
	task automatic t_loads;
		wr(lmx_pkg::OFS_RES, 32'hFFFF);
		chk("ro", lmx_pkg::OFS_RES, 32'h0);
		chk("unmapped", 8'h30, 32'h0);
		wr(lmx_pkg::OFS_OPA, 32'h30);
		wr(lmx_pkg::OFS_OPB, 32'h60);
		ld(lmx_pkg::OP_LDB, 32'h6F);
		wr(lmx_pkg::OFS_OPB, 32'h10);
		ld(lmx_pkg::OP_LDA, 32'h40);
		ld(lmx_pkg::OP_LDB, 32'hFFFF_FFBF);
		ld(lmx_pkg::OP_LDBU, 32'hBF);
		ld(lmx_pkg::OP_LDH, 32'hFFFF_BEBF);
		ld(lmx_pkg::OP_LDHU, 32'hBEBF);
		ld(lmx_pkg::OP_LDW, 32'hBCBD_BEBF);
		run(lmx_pkg::OP_LDD, lmx_pkg::C_NONE);
		chk("flo", lmx_pkg::OFS_FLO, 32'hBCBD_BEBF);
		chk("fhi", lmx_pkg::OFS_FHI, 32'hB8B9_BABB);
		for (int i = 1; i < 4; i++)
		begin
			ctl(4'h1, 32'h40, 2'(i));
			run(lmx_pkg::OP_LDW, i == 1 ? 3'h1 : i == 2 ? 3'h2 : 3'h4);
		end
		ctl(4'h0, 32'h0, lmx_pkg::FLT_NONE);
		wr(lmx_pkg::OFS_OPB, 32'h18);
		run(lmx_pkg::OP_LDS, lmx_pkg::C_NONE);
		chk("flo", lmx_pkg::OFS_FLO, 32'hB4B5_B6B7);
		run(lmx_pkg::OP_LDFS, lmx_pkg::C_NONE);
		chk("res", lmx_pkg::OFS_RES, 32'h0000_2468);
		chk("flo", lmx_pkg::OFS_FLO, 32'h5566_7788);
		chk("fhi", lmx_pkg::OFS_FHI, 32'h1122_3344);
	endtask
	task automatic t_arith;
		xo(lmx_pkg::OP_MODS, 32'h2, 32'hFFFF_FFF9, 32'hFFFF_FFFF, 32'h0);
		xo(lmx_pkg::OP_MODS, 32'hFFFF_FFFE, 32'h7, 32'h1, 32'h0);
		xo(lmx_pkg::OP_MODU, 32'h11, 32'hFFFF_FFFE, 32'h10, 32'h0);
		xo(lmx_pkg::OP_MODS, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0, 32'h2);
		xo(lmx_pkg::OP_LDI16, 32'h0001_8000, 32'h0, 32'hFFFF_8000, 32'h8);
		xo(lmx_pkg::OP_LDQ, 32'hFFFF_FFFF, 32'h0, 32'hF, 32'h0);
		xo(lmx_pkg::OP_LDI16, 32'hFFFF_0000, 32'h0, 32'h0, 32'h4);
		xo(lmx_pkg::OP_LDI32, 32'h8765_4321, 32'h0, 32'h8765_4321, 32'h8);
		xo(lmx_pkg::OP_LDQ, 32'hFFFF_FFF0, 32'h0, 32'h0, 32'h4);
		wr(lmx_pkg::OFS_OPA, 32'h0);
		run(lmx_pkg::OP_MODU, lmx_pkg::C_DIVZ);
		run(lmx_pkg::OP_MODS, lmx_pkg::C_DIVZ);
	endtask
	task automatic t_fill;
		logic [31:0] p;
		p = 32'h1122_3344; // byte string; the pattern rotates one byte per store, so its four bytes repeat
		wr(lmx_pkg::OFS_CNT, 32'h8);
		wr(lmx_pkg::OFS_SRC, 32'h80);
		wr(lmx_pkg::OFS_PAT, p);
		ctl(4'h2, 32'h82, lmx_pkg::FLT_PAGE);
		run(lmx_pkg::OP_FILL, lmx_pkg::C_PAGE);
		chk("cnt", lmx_pkg::OFS_CNT, 32'h6);
		chk("src", lmx_pkg::OFS_SRC, 32'h82);
		chk("pat", lmx_pkg::OFS_PAT, 32'h3344_1122);
		ctl(4'h0, 32'h0, lmx_pkg::FLT_NONE);
		run(lmx_pkg::OP_FILL, lmx_pkg::C_NONE);
		chk("cnt", lmx_pkg::OFS_CNT, 32'h0);
		chk("src", lmx_pkg::OFS_SRC, 32'h88);
		chk("pat", lmx_pkg::OFS_PAT, p);
		for (int i = 0; i < 8; i++)
			`CHK("fill", 8'(p >> (8 * (i % 4))), lmx_mem_i.mem[8'h80 + i])
		`CHK("past", 8'h77, lmx_mem_i.mem[8'h88])
	endtask
	task automatic t_copy;
		wr(lmx_pkg::OFS_CNT, 32'h3);
		wr(lmx_pkg::OFS_SRC, 32'h40);
		wr(lmx_pkg::OFS_PAT, 32'hA0); // ranges kept apart
		ctl(4'h3, 32'h40, lmx_pkg::FLT_PROT);
		run(lmx_pkg::OP_COPY, lmx_pkg::C_RPROT);
		chk("cnt", lmx_pkg::OFS_CNT, 32'h3);
		ctl(4'h3, 32'hA1, lmx_pkg::FLT_PROT);
		run(lmx_pkg::OP_COPY, lmx_pkg::C_WPROT);
		chk("cnt", lmx_pkg::OFS_CNT, 32'h2);
		chk("src", lmx_pkg::OFS_SRC, 32'h41);
		chk("dst", lmx_pkg::OFS_PAT, 32'hA1);
		ctl(4'h0, 32'h0, lmx_pkg::FLT_NONE);
		run(lmx_pkg::OP_COPY, lmx_pkg::C_NONE);
		chk("cnt", lmx_pkg::OFS_CNT, 32'h0);
		chk("src", lmx_pkg::OFS_SRC, 32'h43);
		chk("dst", lmx_pkg::OFS_PAT, 32'hA3);
		for (int i = 0; i < 3; i++)
			`CHK("copy", 8'(~(8'h40 + i)), lmx_mem_i.mem[8'hA0 + i])
	endtask
	//==========================================
	// run control
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		#400000;
		error_cnt++;
		end_of_test;
	end
	initial
	begin
		i_resetn = 1'b0;
		i_addr = 8'h0;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_fp_pc = 32'h0000_2468;
		i_fp_dest = 64'h1122_3344_5566_7788;
		delay = 4'h0;
		flt_addr = 32'h0;
		flt_code = 2'h0;
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_loads;
		t_arith;
		t_fill;
		t_copy;
		end_of_test;
	end
endmodule

//--- lmx_mem.sv
// memory partner: byte store with adjustable delay and one faulting address
`timescale 1ns/1ps
module lmx_mem (
	// clock
	input wire logic i_clk,
	// access from the unit
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [1:0] i_size,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	output logic o_ack,
	output logic [1:0] o_fault,
	output logic [31:0] o_rdata,
	// scenario control
	input wire logic [3:0] i_delay,
	input wire logic [31:0] i_flt_addr,
	input wire logic [1:0] i_flt_code
);
	logic [7:0] mem [0:255];
	logic [3:0] cnt;
	logic [7:0] a;
	logic hit;
	logic [31:0] keep;
	assign a = i_addr[7:0];
	// bytes beyond the access size read as zero, so a wrong size shows in the result
	assign keep = (i_size == lmx_pkg::SZ_B) ? 32'h0000_00FF
		: (i_size == lmx_pkg::SZ_H) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
	assign hit = (i_addr == i_flt_addr) && (i_flt_code != lmx_pkg::FLT_NONE);
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(~i);
		o_ack = 1'b0;
		o_fault = 2'h0;
		o_rdata = 32'h0;
		cnt = 4'h0;
	end
	// outside an ack the data lines churn, so stale values never look valid
	always @(posedge i_clk)
	begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		o_fault <= ~o_fault;
		if (i_req && !o_ack)
		begin
			if (cnt != i_delay)
				cnt <= cnt + 4'h1;
			else
			begin
				cnt <= 4'h0;
				o_ack <= 1'b1;
				o_fault <= hit ? i_flt_code : lmx_pkg::FLT_NONE;
				o_rdata <= {mem[a + 8'd3], mem[a + 8'd2], mem[a + 8'd1], mem[a]} & keep;
				// wider stores spill into the next bytes, so a wrong size is visible
				if (i_we && !hit)
				begin
					mem[a] <= i_wdata[7:0];
					if (i_size != lmx_pkg::SZ_B)
						mem[a + 8'd1] <= i_wdata[15:8];
					if (i_size == lmx_pkg::SZ_W)
					begin
						mem[a + 8'd2] <= i_wdata[23:16];
						mem[a + 8'd3] <= i_wdata[31:24];
					end
				end
			end
		end
	end
endmodule

//--- lmx_mod.sv
// shared constants and the sequential modulus unit
`timescale 1ns/1ps
//==========================================
// package
package lmx_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_OPA = 8'h04;
	localparam logic [7:0] OFS_OPB = 8'h08;
	localparam logic [7:0] OFS_RES = 8'h0C;
	localparam logic [7:0] OFS_FLO = 8'h10;
	localparam logic [7:0] OFS_FHI = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_CNT = 8'h1C;
	localparam logic [7:0] OFS_SRC = 8'h20;
	localparam logic [7:0] OFS_PAT = 8'h24;
	localparam int CTRL_BUSY_BIT = 8;
	localparam int CTRL_CAUSE_LSB = 12;
	localparam int FLG_N = 3;
	localparam int FLG_Z = 2;
	localparam int FLG_V = 1;
	localparam int FLG_C = 0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [1:0] SZ_B = 2'h0;
	localparam logic [1:0] SZ_H = 2'h1;
	localparam logic [1:0] SZ_W = 2'h2;
	localparam logic [1:0] FLT_NONE = 2'h0;
	localparam logic [1:0] FLT_PAGE = 2'h1;
	localparam logic [1:0] FLT_PROT = 2'h2;
	localparam logic [1:0] FLT_MEM = 2'h3;
	typedef enum logic [3:0] {
		OP_LDA = 4'h0, OP_LDB = 4'h1, OP_LDBU = 4'h2, OP_LDH = 4'h3,
		OP_LDHU = 4'h4, OP_LDW = 4'h5, OP_LDS = 4'h6, OP_LDD = 4'h7,
		OP_LDFS = 4'h8, OP_LDI16 = 4'h9, OP_LDI32 = 4'hA, OP_LDQ = 4'hB,
		OP_MODS = 4'hC, OP_MODU = 4'hD, OP_FILL = 4'hE, OP_COPY = 4'hF
	} lmx_op_t;
	typedef enum logic [2:0] {
		C_NONE = 3'h0, C_PAGE = 3'h1, C_RPROT = 3'h2, C_WPROT = 3'h3,
		C_MEM = 3'h4, C_DIVZ = 3'h5
	} lmx_cause_t;
endpackage

//==========================================
// modulus unit: one quotient bit per cycle
module lmx_mod #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// request
	input wire logic i_start,
	input wire logic i_signed,
	input wire logic [W-1:0] i_dividend,
	input wire logic [W-1:0] i_divisor,
	// answer
	output logic o_done,
	output logic [W-1:0] o_rem,
	output logic o_ovf
);
	localparam int CW = $clog2(W);
	localparam logic [W-1:0] MIN_NEG = {1'b1, {(W-1){1'b0}}};
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic run_ff, nxt_run, neg_ff, nxt_neg, ovf_ff, nxt_ovf, done_ff, nxt_done;
	logic [W-1:0] rem_ff, nxt_rem, quo_ff, nxt_quo, dvs_ff, nxt_dvs, out_ff, nxt_out;
	logic [W:0] trial;
	logic [W-1:0] step_rem;

	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_neg = neg_ff;
		nxt_ovf = ovf_ff;
		nxt_rem = rem_ff;
		nxt_quo = quo_ff;
		nxt_dvs = dvs_ff;
		nxt_out = out_ff;
		nxt_done = 1'b0;
		trial = {rem_ff, quo_ff[W-1]};
		step_rem = (trial >= {1'b0, dvs_ff}) ? W'(trial - {1'b0, dvs_ff}) : trial[W-1:0];
		if (i_start)
		begin
			// remainder follows the dividend's sign
			nxt_neg = i_signed & i_dividend[W-1];
			nxt_quo = (i_signed && i_dividend[W-1]) ? W'(-i_dividend) : i_dividend;
			nxt_dvs = (i_signed && i_divisor[W-1]) ? W'(-i_divisor) : i_divisor;
			nxt_ovf = i_signed && (i_dividend == MIN_NEG) && (&i_divisor);
			nxt_rem = '0;
			nxt_cnt = '0;
			nxt_run = 1'b1;
		end
		else if (run_ff)
		begin
			nxt_quo = {quo_ff[W-2:0], 1'b0};
			nxt_rem = step_rem;
			nxt_cnt = CW'(cnt_ff + 1'b1);
			if (cnt_ff == CW'(W-1))
			begin
				nxt_run = 1'b0;
				nxt_done = 1'b1;
				nxt_out = neg_ff ? W'(-step_rem) : step_rem;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
			neg_ff <= 1'b0;
			ovf_ff <= 1'b0;
			done_ff <= 1'b0;
			rem_ff <= '0;
			quo_ff <= '0;
			dvs_ff <= '0;
			out_ff <= '0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			neg_ff <= nxt_neg;
			ovf_ff <= nxt_ovf;
			done_ff <= nxt_done;
			rem_ff <= nxt_rem;
			quo_ff <= nxt_quo;
			dvs_ff <= nxt_dvs;
			out_ff <= nxt_out;
		end
	end

	assign o_done = done_ff;
	assign o_rem = out_ff;
	assign o_ovf = ovf_ff;
endmodule
